//--- hw/ice_pkg.sv
// Purpose: shared costs, types and helpers of the cycle estimator
// Assumes: a memory operand always takes at least one bus cycle
// Notes: every cost is counted in processor clock cycles
package ice_pkg;

  // ==========================================================
  // Address costs per addressing mode
  localparam logic [7:0] EA_IMM_ABS = 8'h04;
  localparam logic [7:0] EA_REG = 8'h02;
  localparam logic [7:0] EA_REL = 8'h05;
  localparam logic [7:0] EA_MEMREL = 8'h07;
  localparam logic [7:0] EA_EXT = 8'h0B;
  localparam logic [7:0] EA_TOS_WR = 8'h04;
  localparam logic [7:0] EA_TOS_RD = 8'h02;
  localparam logic [7:0] EA_TOS_RMW = 8'h03;
  localparam logic [7:0] IDX_BASE_REG = 8'h05;
  localparam logic [7:0] IDX_BASE_TOS = 8'h04;
  localparam logic [7:0] IDX_SC_B = 8'h05;
  localparam logic [7:0] IDX_SC_W = 8'h07;
  localparam logic [7:0] IDX_SC_D = 8'h08;
  localparam logic [7:0] IDX_SC_Q = 8'h0A;

  // ==========================================================
  // Operand transfer and length costs
  localparam logic [7:0] BYTE_XFER = 8'h03;
  localparam logic [7:0] CYC_PER_BUS = 8'h04;
  localparam logic [7:0] BUS_ADJ = 8'h01;
  localparam logic [7:0] LEN_B = 8'h01;
  localparam logic [7:0] LEN_W = 8'h02;
  localparam logic [7:0] LEN_D = 8'h04;

  // ==========================================================
  // Overhead, string move and coprocessor costs
  localparam logic [8:0] FLUSH_ONE = 9'h006;
  localparam logic [8:0] FLUSH_MULTI = 9'h005;
  localparam logic [3:0] STR_HIDE_BW = 4'hD;
  localparam logic [3:0] STR_HIDE_D = 4'h4;
  localparam logic [1:0] FP_SHORT = 2'h1;
  localparam logic [1:0] FP_LONG = 2'h2;
  localparam logic [7:0] TF_CYC = 8'h04;
  localparam logic [7:0] TI_BW = 8'h02;
  localparam logic [7:0] TI_D = 8'h04;
  localparam logic [8:0] FP_OVL = 9'h003;

  // ==========================================================
  // Enumerations
  typedef enum logic [3:0] {
    M_IMM, M_ABS, M_REG, M_REL, M_MSPACE, M_MEMREL, M_EXT, M_TOS,
    M_SCALED
  } ice_mode_e;
  typedef enum logic [1:0] {ACC_RD, ACC_WR, ACC_RMW} ice_acc_e;
  typedef enum logic [1:0] {SZ_B, SZ_W, SZ_D} ice_size_e;
  typedef enum logic [1:0] {SC_B, SC_W, SC_D, SC_Q} ice_scale_e;
  typedef enum logic [1:0] {SEL_OPLEN, SEL_B, SEL_W, SEL_D} ice_sel_e;
  typedef enum logic [1:0] {TCY_FIXED, TCY_RANGE, TCY_FLUSH} ice_tcy_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    ice_mode_e mode;
    ice_mode_e base;
    ice_scale_e scale;
    ice_acc_e acc;
    logic ea_need;
    logic [2:0] ptr_operand_bus_cycles;
    logic [3:0] ptr_waits;
    logic [2:0] operand_bus_cycles;
    logic [3:0] waits;
    logic [1:0] xfer_cnt;
    ice_sel_e xfer_sel;
  } ice_opnd_s;

  typedef struct packed {
    ice_opnd_s [1:0] opnd;
    ice_size_e op_len;
    logic [2:0] l_cnt;
    ice_tcy_e tcy_kind;
    logic [7:0] n1;
    logic [7:0] n2;
    logic fetch_one;
    logic [7:0] fetch_cyc;
    logic str_en;
    logic [7:0] str_writes;
    logic [3:0] str_waits;
    logic overlap_en;
    logic fp_en;
    logic fp_long;
    logic [1:0] tf_cnt;
    logic [1:0] ti_cnt;
    ice_size_e int_size;
    logic [7:0] parallel_cpu_cycles;
    logic [7:0] coproc_exec_cycles;
  } ice_req_s;

  typedef struct packed {
    logic [11:0] total_min;
    logic [11:0] total_max;
    logic [7:0] ea1;
    logic [7:0] ea2;
    logic [9:0] xfer;
    logic [7:0] len_cyc;
    logic [8:0] tcy_min;
    logic [8:0] tcy_max;
    logic [9:0] fp;
    logic [8:0] hidden;
  } ice_res_s;

  // ==========================================================
  // Helpers
  // Register and immediate operands never touch memory
  function automatic logic is_mem(ice_mode_e m);
    is_mem = (m != M_IMM) && (m != M_REG);
  endfunction

  // One operand transfer, wait states charged per bus cycle
  function automatic logic [7:0] xfer_cost(ice_size_e sz,
      logic [2:0] operand_bus_cycles, logic [3:0] waits, logic mem);
    logic [7:0] c;
    c = 8'h00;
    if (mem && sz == SZ_B) begin
      c = BYTE_XFER + 8'(waits);
    end else if (mem) begin
      c = 8'(operand_bus_cycles) * (CYC_PER_BUS + 8'(waits)) - BUS_ADJ;
    end
    xfer_cost = c;
  endfunction

  function automatic logic [7:0] len_bytes(ice_size_e sz);
    len_bytes = (sz == SZ_B) ? LEN_B : (sz == SZ_W) ? LEN_W : LEN_D;
  endfunction

endpackage

//--- hw/ice_ea_cost.sv
// Purpose: effective address cost of one operand
// Assumes: a scaled mode never names scaled as its base
// Notes: pointer fetches of indirect modes are double-word reads
module ice_ea_cost (
  // Operand description
  input ice_pkg::ice_opnd_s opnd,
  // Address cost
  output logic [7:0] cost
);

  // ==========================================================
  // Cost of a plain, unindexed mode
  function automatic logic [7:0] ea_plain(ice_pkg::ice_mode_e m,
      ice_pkg::ice_acc_e a, logic [7:0] ptr);
    logic [7:0] c;
    c = 8'h00;
    case (m)
      ice_pkg::M_IMM, ice_pkg::M_ABS: c = ice_pkg::EA_IMM_ABS;
      ice_pkg::M_REG: c = ice_pkg::EA_REG;
      ice_pkg::M_REL, ice_pkg::M_MSPACE: c = ice_pkg::EA_REL;
      ice_pkg::M_MEMREL: c = ice_pkg::EA_MEMREL + ptr;
      ice_pkg::M_EXT: c = ice_pkg::EA_EXT + {ptr[6:0], 1'b0};
      ice_pkg::M_TOS: begin
        if (a == ice_pkg::ACC_WR) c = ice_pkg::EA_TOS_WR;
        else if (a == ice_pkg::ACC_RMW) c = ice_pkg::EA_TOS_RMW;
        else c = ice_pkg::EA_TOS_RD;
      end
      default: c = 8'h00; // Scaled has no plain cost
    endcase
    ea_plain = c;
  endfunction

  logic [7:0] ptr_cyc;
  logic [7:0] base_cyc;
  logic [7:0] scale_cyc;

  // Base, scale and total cost
  always_comb begin
    ptr_cyc = ice_pkg::xfer_cost(ice_pkg::SZ_D, opnd.ptr_operand_bus_cycles,
        opnd.ptr_waits, 1'b1);
    unique case (opnd.base) // R3
      ice_pkg::M_REG: base_cyc = ice_pkg::IDX_BASE_REG;
      ice_pkg::M_TOS: base_cyc = ice_pkg::IDX_BASE_TOS;
      default: base_cyc = ea_plain(opnd.base, opnd.acc, ptr_cyc);
    endcase
    unique case (opnd.scale) // R4
      ice_pkg::SC_B: scale_cyc = ice_pkg::IDX_SC_B;
      ice_pkg::SC_W: scale_cyc = ice_pkg::IDX_SC_W;
      ice_pkg::SC_D: scale_cyc = ice_pkg::IDX_SC_D;
      ice_pkg::SC_Q: scale_cyc = ice_pkg::IDX_SC_Q;
    endcase
    if (opnd.mode == ice_pkg::M_SCALED) begin
      cost = base_cyc + scale_cyc; // R3
    end else begin
      cost = ea_plain(opnd.mode, opnd.acc, ptr_cyc); // R2
    end
  end

endmodule

//--- hw/ice_estimator.sv
// Purpose: instruction execution cycle estimate, one per request
// Assumes: table entries and bus details arrive on the request
// Notes: result appears one clock after the request is taken
//
// Functional notes
// [R1] Register or immediate fetch sits in address cost
// [R2] Fixed address cost per addressing mode
// [R3] Scaled index base cost with two overrides
// [R4] Scale cost by index width
// [R5] Byte transfer zero or three cycles
// [R6] Memory transfer four per bus cycle less one
// [R7] Sized transfer follows operation length
// [R8] Length term times operation bytes
// [R9] Float size factor one or two
// [R10] Each 32-bit float piece costs four
// [R11] Integer coprocessor move two or four
// [R12] Address cost only when flagged needed
// [R13] Overhead range gives minimum and maximum
// [R14] Queue flush entry uses flush point
// [R15] Flush overhead adds six or five plus fetch
// [R16] String write waits hide in overhead, capped
// [R17] Immediate overhead equals register overhead
// [R18] Read-modify-write final write overlaps next instruction
// [R19] Operand fetches overlap later address and execution
// [R20] Coprocessor time runs from last data word
// [R21] Unranged values use worst case
// [R22] Total is sum of all terms
// [R23] Overlap term is larger of two
// [R24] Inputs in, cycle total out, one evaluation
module ice_estimator (
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // Request
  input logic req_valid,
  input ice_pkg::ice_req_s req,
  // Result
  output logic res_valid,
  output ice_pkg::ice_res_s res
);

  // ==========================================================
  // Declarations
  logic [1:0][7:0] ea_cyc;
  logic [1:0][7:0] one_xfer;
  logic [1:0][9:0] xfer_cyc;
  logic [1:0] mem;
  logic [7:0] len_cyc;
  logic [8:0] tcy_lo;
  logic [8:0] tcy_hi;
  logic [8:0] tcy_min;
  logic [8:0] tcy_max;
  logic [3:0] str_wait;
  logic [11:0] str_cut;
  logic rmw2;
  logic [8:0] hide_wr;
  logic [8:0] hide_f1;
  logic [8:0] hide_f2;
  logic [8:0] hidden;
  logic [1:0] fp_f;
  logic [8:0] fp_ovl;
  logic [9:0] fp_cyc;
  ice_pkg::ice_res_s res_d;
  ice_pkg::ice_res_s res_q;
  logic valid_d;
  logic valid_q;

  function automatic logic [8:0] min9(logic [8:0] a, logic [8:0] b);
    min9 = (a < b) ? a : b;
  endfunction

  // ==========================================================
  // Per-operand address and transfer costs
  for (genvar i = 0; i < 2; i++) begin : g_opnd
    ice_pkg::ice_size_e sz;
    logic [7:0] ea_raw;

    ice_ea_cost u_ea (
      .opnd(req.opnd[i]),
      .cost(ea_raw)
    );

    // Transfer width, fixed or from operation length
    always_comb begin
      unique case (req.opnd[i].xfer_sel)
        ice_pkg::SEL_OPLEN: sz = req.op_len; // R7
        ice_pkg::SEL_B: sz = ice_pkg::SZ_B;
        ice_pkg::SEL_W: sz = ice_pkg::SZ_W;
        ice_pkg::SEL_D: sz = ice_pkg::SZ_D;
      endcase
    end

    // Fetch of a register operand is already in its address cost
    assign mem[i] = ice_pkg::is_mem(req.opnd[i].mode); // R1
    assign ea_cyc[i] = req.opnd[i].ea_need ? ea_raw : 8'h00; // R12
    assign one_xfer[i] = ice_pkg::xfer_cost(sz, req.opnd[i].operand_bus_cycles,
        req.opnd[i].waits, mem[i]); // R5 R6
    assign xfer_cyc[i] = 10'(one_xfer[i]) * 10'(req.opnd[i].xfer_cnt);
  end

  // Length-scaled internal processing
  assign len_cyc = 8'(req.l_cnt) * ice_pkg::len_bytes(req.op_len); // R8

  // ==========================================================
  // Internal overhead
  // The entry is the register form; immediates reuse it as is
  always_comb begin
    tcy_lo = 9'(req.n1); // R17
    tcy_hi = 9'(req.n1);
    unique case (req.tcy_kind)
      ice_pkg::TCY_FIXED: tcy_hi = 9'(req.n1); // R21
      ice_pkg::TCY_RANGE: tcy_hi = 9'(req.n2); // R13
      ice_pkg::TCY_FLUSH: begin
        // Flush point, then refetch of opcode and index bytes
        tcy_lo = 9'(req.n1) + 9'(req.fetch_cyc) + (req.fetch_one ?
            ice_pkg::FLUSH_ONE : ice_pkg::FLUSH_MULTI); // R14 R15
        tcy_hi = tcy_lo;
      end
      default: tcy_hi = 9'(req.n1); // Unused code, worst as fixed
    endcase
  end

  // String move write waits absorbed by pointer updates
  always_comb begin
    str_wait = (req.op_len == ice_pkg::SZ_D) ? ice_pkg::STR_HIDE_D :
        ice_pkg::STR_HIDE_BW;
    if (req.str_waits < str_wait) str_wait = req.str_waits; // R16
    str_cut = 12'(str_wait) * 12'(req.str_writes);
    tcy_min = tcy_lo;
    tcy_max = tcy_hi;
    if (req.str_en) begin
      // Saturate: overhead never drops below zero
      tcy_min = (str_cut >= 12'(tcy_lo)) ? 9'h000 :
          tcy_lo - str_cut[8:0]; // R16
      tcy_max = (str_cut >= 12'(tcy_hi)) ? 9'h000 :
          tcy_hi - str_cut[8:0];
    end
  end

  // ==========================================================
  // Overlap credits, only when the caller asks for them
  // Pessimistic by default: all transfers finish before next start
  always_comb begin
    rmw2 = req.opnd[1].acc == ice_pkg::ACC_RMW;
    hide_wr = 9'h000;
    hide_f1 = 9'h000;
    hide_f2 = 9'h000;
    if (req.overlap_en) begin
      if (mem[1] && rmw2 && req.opnd[1].xfer_cnt != 2'h0) begin
        hide_wr = 9'(one_xfer[1]); // R18
      end
      if (mem[0] && req.opnd[0].xfer_cnt != 2'h0) begin
        hide_f1 = min9(9'(one_xfer[0]), 9'(ea_cyc[1])); // R19
      end
      if (mem[1] && req.opnd[1].xfer_cnt > {1'b0, rmw2}) begin
        hide_f2 = min9(9'(one_xfer[1]), tcy_min); // R19
      end
    end
    hidden = hide_wr + hide_f1 + hide_f2;
  end

  // ==========================================================
  // Coprocessor terms
  // The coprocessor time counts from the last word sent
  always_comb begin
    fp_f = req.fp_long ? ice_pkg::FP_LONG : ice_pkg::FP_SHORT; // R9
    fp_ovl = 9'(req.coproc_exec_cycles) + ice_pkg::FP_OVL; // R20
    if (9'(req.parallel_cpu_cycles) > fp_ovl) fp_ovl = 9'(req.parallel_cpu_cycles); // R23
    fp_cyc = 10'h000;
    if (req.fp_en) begin
      fp_cyc = 10'(req.tf_cnt) * 10'(fp_f) * 10'(ice_pkg::TF_CYC) // R10
          + 10'(req.ti_cnt) * 10'((req.int_size == ice_pkg::SZ_D) ?
          ice_pkg::TI_D : ice_pkg::TI_BW) // R11
          + 10'(fp_ovl);
    end
  end

  // ==========================================================
  // Result assembly and result register
  always_comb begin
    res_d.ea1 = ea_cyc[0];
    res_d.ea2 = ea_cyc[1];
    res_d.xfer = xfer_cyc[0] + xfer_cyc[1];
    res_d.len_cyc = len_cyc;
    res_d.tcy_min = tcy_min;
    res_d.tcy_max = tcy_max;
    res_d.fp = fp_cyc;
    res_d.hidden = hidden;
    res_d.total_min = 12'(ea_cyc[0]) + 12'(ea_cyc[1])
        + 12'(res_d.xfer) + 12'(len_cyc) + 12'(tcy_min)
        + 12'(fp_cyc) - 12'(hidden); // R22
    res_d.total_max = 12'(ea_cyc[0]) + 12'(ea_cyc[1])
        + 12'(res_d.xfer) + 12'(len_cyc) + 12'(tcy_max)
        + 12'(fp_cyc) - 12'(hidden); // R22
    valid_d = req_valid;
  end

  // Whole estimate in a single evaluation, registered once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_q <= '0;
      valid_q <= 1'b0;
    end else begin
      res_q <= valid_d ? res_d : res_q; // R24
      valid_q <= valid_d;
    end
  end

  assign res = res_q;
  assign res_valid = valid_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_one_req;
    req_valid ##1 !req_valid;
  endsequence

  sequence s_one_res;
    res_valid ##1 !res_valid;
  endsequence

  sequence s_reg_ea1;
    req_valid && req.opnd[0].ea_need
        && req.opnd[0].mode == ice_pkg::M_REG;
  endsequence

  sequence s_scaled_reg_w;
    req_valid && req.opnd[1].ea_need
        && req.opnd[1].mode == ice_pkg::M_SCALED
        && req.opnd[1].base == ice_pkg::M_REG
        && req.opnd[1].scale == ice_pkg::SC_W;
  endsequence

  a_res_timing: assert property ( // R24
    s_one_req |-> s_one_res)
    else $error("result valid does not follow a single request");

  a_ea_gate_off: assert property ( // R12
    req_valid && !req.opnd[0].ea_need |=> res.ea1 == 8'h00)
    else $error("address cost charged for unflagged operand");

  a_ea_reg_cost: assert property ( // R2
    s_reg_ea1 |=> res.ea1 == ice_pkg::EA_REG)
    else $error("register mode address cost wrong");

  a_scaled_cost: assert property ( // R3
    s_scaled_reg_w |=> res.ea2 == ice_pkg::IDX_BASE_REG
        + ice_pkg::IDX_SC_W)
    else $error("scaled register word index cost wrong");

  a_no_reg_xfer: assert property ( // R1
    req_valid && !ice_pkg::is_mem(req.opnd[0].mode)
        && !ice_pkg::is_mem(req.opnd[1].mode)
        |=> res.xfer == 10'h000)
    else $error("transfer cost charged for register operands");

  a_len_scaled: assert property ( // R8
    req_valid |=> res.len_cyc == 8'($past(req.l_cnt))
        * ice_pkg::len_bytes($past(req.op_len)))
    else $error("length term not scaled by operation bytes");

  a_range_keep: assert property ( // R13
    req_valid && req.tcy_kind == ice_pkg::TCY_RANGE && !req.str_en
        |=> res.tcy_min == 9'($past(req.n1))
        && res.tcy_max == 9'($past(req.n2)))
    else $error("overhead range not kept as minimum and maximum");

  a_flush_one: assert property ( // R15
    req_valid && req.tcy_kind == ice_pkg::TCY_FLUSH && req.fetch_one
        && !req.str_en
        |=> res.tcy_max == 9'($past(req.n1)) + ice_pkg::FLUSH_ONE
        + 9'($past(req.fetch_cyc)))
    else $error("single fetch flush overhead wrong");

  a_fp_overlap: assert property ( // R23
    req_valid && req.fp_en && req.tf_cnt == 2'h0 && req.ti_cnt == 2'h0
        |=> res.fp == ((10'($past(req.parallel_cpu_cycles))
        > 10'($past(req.coproc_exec_cycles)) + 10'(ice_pkg::FP_OVL))
        ? 10'($past(req.parallel_cpu_cycles))
        : 10'($past(req.coproc_exec_cycles)) + 10'(ice_pkg::FP_OVL)))
    else $error("coprocessor overlap term wrong");

  a_total_sum: assert property ( // R22
    res_valid |-> res.total_max + 12'(res.hidden) == 12'(res.ea1)
        + 12'(res.ea2) + 12'(res.xfer) + 12'(res.len_cyc)
        + 12'(res.tcy_max) + 12'(res.fp))
    else $error("total is not the sum of its terms");

  a_min_le_max: assert property ( // R21
    res_valid |-> res.total_min <= res.total_max)
    else $error("minimum total above maximum total");

endmodule

//--- sim/test_instruction_cycle_estimator.sv
// Purpose: self-checking bench of the cycle estimator
// Assumes: one request per clock, result one clock after it is taken
// Notes: overlap credit is drawn at random, so both totals get exercised
module test_instruction_cycle_estimator;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  ice_pkg::ice_req_s req = '0;
  logic res_valid;
  ice_pkg::ice_res_s res;
  ice_pkg::ice_res_s exp_q = '0;
  logic pend_q = 1'b0;
  ice_pkg::ice_req_s r;
  int miscompares = 0;
  int samples_checked = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  ice_estimator dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .res_valid(res_valid), .res(res));

  // ==========================================================
  // Reference model, plain integers
  function automatic int ea_of(ice_pkg::ice_opnd_s o, ice_pkg::ice_mode_e m);
    int p;
    int sc[4];
    sc = '{5, 7, 8, 10};
    p = o.ptr_operand_bus_cycles * (4 + o.ptr_waits) - 1;
    case (m)
      ice_pkg::M_IMM, ice_pkg::M_ABS: return 4;
      ice_pkg::M_REG: return 2;
      ice_pkg::M_MEMREL: return 7 + p;
      ice_pkg::M_EXT: return 11 + 2 * p;
      ice_pkg::M_TOS: return (o.acc == ice_pkg::ACC_WR) ? 4 :
        (o.acc == ice_pkg::ACC_RD) ? 2 : 3;
      ice_pkg::M_SCALED: return sc[o.scale] +
        ((o.base == ice_pkg::M_REG) ? 5 : (o.base == ice_pkg::M_TOS) ? 4 :
        (o.base == ice_pkg::M_SCALED) ? 0 : ea_of(o, o.base));
      default: return 5;
    endcase
  endfunction

  // One transfer; register and immediate operands cost nothing
  function automatic int xf(ice_pkg::ice_opnd_s o, ice_pkg::ice_size_e len);
    int sz;
    sz = (o.xfer_sel == ice_pkg::SEL_OPLEN) ? int'(len) : int'(o.xfer_sel) - 1;
    if (o.mode == ice_pkg::M_IMM || o.mode == ice_pkg::M_REG) return 0;
    if (sz == 0) return 3 + o.waits;
    return o.operand_bus_cycles * (4 + o.waits) - 1;
  endfunction

  function automatic ice_pkg::ice_res_s model(ice_pkg::ice_req_s q);
    ice_pkg::ice_res_s e;
    int lo, hi, red, cap, fp, x, a1, a2, ln, x0, x1, r2, hd;
    e = '0;
    a1 = q.opnd[0].ea_need ? ea_of(q.opnd[0], q.opnd[0].mode) : 0;
    a2 = q.opnd[1].ea_need ? ea_of(q.opnd[1], q.opnd[1].mode) : 0;
    x = q.opnd[0].xfer_cnt * xf(q.opnd[0], q.op_len) +
      q.opnd[1].xfer_cnt * xf(q.opnd[1], q.op_len);
    ln = q.l_cnt * ((q.op_len == ice_pkg::SZ_B) ? 1 :
      (q.op_len == ice_pkg::SZ_W) ? 2 : 4);
    lo = q.n1;
    hi = (q.tcy_kind == ice_pkg::TCY_RANGE) ? int'(q.n2) : lo;
    if (q.tcy_kind == ice_pkg::TCY_FLUSH) begin
      lo = q.n1 + (q.fetch_one ? 6 : 5) + q.fetch_cyc;
      hi = lo;
    end
    cap = (q.op_len == ice_pkg::SZ_D) ? 4 : 13;
    red = q.str_en ? ((q.str_waits < cap) ? q.str_waits : cap) * q.str_writes
      : 0;
    lo = (lo > red) ? lo - red : 0;
    hi = (hi > red) ? hi - red : 0;
    x0 = xf(q.opnd[0], q.op_len);
    x1 = xf(q.opnd[1], q.op_len);
    r2 = (q.opnd[1].acc == ice_pkg::ACC_RMW) ? 1 : 0;
    hd = 0;
    if (q.overlap_en) begin
      // Final rmw write, first fetch under second address, second under work
      if (r2 == 1 && q.opnd[1].xfer_cnt != 0) hd += x1;
      if (q.opnd[0].xfer_cnt != 0) hd += (x0 < a2) ? x0 : a2;
      if (q.opnd[1].xfer_cnt > r2) hd += (x1 < lo) ? x1 : lo;
    end
    fp = 0;
    if (q.fp_en) begin
      fp = q.tf_cnt * (q.fp_long ? 2 : 1) * 4 +
        q.ti_cnt * ((q.int_size == ice_pkg::SZ_D) ? 4 : 2) +
        ((q.parallel_cpu_cycles > q.coproc_exec_cycles + 3) ? int'(q.parallel_cpu_cycles) : q.coproc_exec_cycles + 3);
    end
    e.ea1 = 8'(a1);
    e.ea2 = 8'(a2);
    e.xfer = 10'(x);
    e.len_cyc = 8'(ln);
    e.tcy_min = 9'(lo);
    e.tcy_max = 9'(hi);
    e.fp = 10'(fp);
    e.hidden = 9'(hd);
    e.total_min = 12'(a1 + a2 + x + ln + lo + fp - hd);
    e.total_max = 12'(a1 + a2 + x + ln + hi + fp - hd);
    return e;
  endfunction

  // Legal random request, memory operands take one bus cycle or more
  function automatic ice_pkg::ice_req_s rnd();
    ice_pkg::ice_req_s q;
    q = '0;
    for (int i = 0; i < 2; i++) begin
      q.opnd[i].mode = ice_pkg::ice_mode_e'($urandom_range(8));
      q.opnd[i].base = ice_pkg::ice_mode_e'($urandom_range(7));
      q.opnd[i].scale = ice_pkg::ice_scale_e'($urandom_range(3));
      q.opnd[i].acc = ice_pkg::ice_acc_e'($urandom_range(2));
      q.opnd[i].ea_need = 1'($urandom_range(1));
      q.opnd[i].ptr_operand_bus_cycles = 3'($urandom_range(2, 1));
      q.opnd[i].ptr_waits = 4'($urandom_range(3));
      q.opnd[i].operand_bus_cycles = 3'($urandom_range(4, 1));
      q.opnd[i].waits = 4'($urandom_range(3));
      q.opnd[i].xfer_cnt = 2'($urandom);
      q.opnd[i].xfer_sel = ice_pkg::ice_sel_e'($urandom_range(3));
    end
    q.op_len = ice_pkg::ice_size_e'($urandom_range(2));
    q.l_cnt = 3'($urandom);
    q.tcy_kind = ice_pkg::ice_tcy_e'($urandom_range(2));
    q.n1 = 8'($urandom_range(60));
    q.n2 = q.n1 + 8'($urandom_range(60));
    q.fetch_one = 1'($urandom);
    q.fetch_cyc = 8'($urandom_range(15));
    q.str_en = 1'($urandom);
    q.str_writes = 8'($urandom_range(7));
    q.str_waits = 4'($urandom);
    q.overlap_en = 1'($urandom);
    q.fp_en = 1'($urandom);
    q.fp_long = 1'($urandom);
    q.tf_cnt = 2'($urandom);
    q.ti_cnt = 2'($urandom);
    q.int_size = ice_pkg::ice_size_e'($urandom_range(2));
    q.parallel_cpu_cycles = 8'($urandom_range(99));
    q.coproc_exec_cycles = 8'($urandom_range(99));
    return q;
  endfunction

  // ==========================================================
  // Checking
  task automatic check(input logic [11:0] seen, input logic [11:0] want,
      input string what);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR %0t %s seen %0d want %0d", $time, what, seen, want);
    end
  endtask

  // Model takes each request on the same edge as the design
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
      exp_q <= '0;
    end else begin
      pend_q <= req_valid;
      if (req_valid) exp_q <= model(req);
    end
  end

  // Compare every cycle; results must also hold between requests
  always @(negedge clk) begin
    check(12'(res_valid), 12'(pend_q), "valid");
    check(12'(res.ea1), 12'(exp_q.ea1), "ea1");
    check(12'(res.ea2), 12'(exp_q.ea2), "ea2");
    check(12'(res.xfer), 12'(exp_q.xfer), "xfer");
    check(12'(res.len_cyc), 12'(exp_q.len_cyc), "len");
    check(12'(res.tcy_min), 12'(exp_q.tcy_min), "tcy_min");
    check(12'(res.tcy_max), 12'(exp_q.tcy_max), "tcy_max");
    check(12'(res.fp), 12'(exp_q.fp), "fp");
    check(12'(res.hidden), 12'(exp_q.hidden), "hidden");
    check(res.total_min, exp_q.total_min, "total_min");
    check(res.total_max, exp_q.total_max, "total_max");
  end

  // ==========================================================
  // Drivers and closing
  task automatic send(input ice_pkg::ice_req_s q, input logic v);
    @(negedge clk);
    req <= q;
    req_valid <= v;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(4 * 5000);
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end

  // ==========================================================
  // Tests
  initial begin
    void'($urandom(92252));
    repeat (3) @(negedge clk);
    sys_rst <= 1'b0;
    // Word compare, register against stack read
    r = '0;
    r.opnd[0].mode = ice_pkg::M_REG;
    r.opnd[0].ea_need = 1'b1;
    r.opnd[0].xfer_cnt = 2'h1;
    r.opnd[1].mode = ice_pkg::M_TOS;
    r.opnd[1].acc = ice_pkg::ACC_RD;
    r.opnd[1].ea_need = 1'b1;
    r.opnd[1].operand_bus_cycles = 3'h1;
    r.opnd[1].xfer_cnt = 2'h1;
    r.op_len = ice_pkg::SZ_W;
    r.n1 = 8'h03;
    send(r, 1'b1);
    send(r, 1'b0);
    @(negedge clk);
    check(res.total_min, 12'h00A, "example total");
    $display("test example done");
    // Every mode and access class, back to back
    for (int m = 0; m < 9; m++) begin
      for (int a = 0; a < 3; a++) begin
        r = rnd();
        r.opnd[0].mode = ice_pkg::ice_mode_e'(m);
        r.opnd[1].mode = ice_pkg::ice_mode_e'(m);
        r.opnd[0].acc = ice_pkg::ice_acc_e'(a);
        r.opnd[1].acc = ice_pkg::ice_acc_e'(a);
        r.opnd[0].ea_need = 1'b1;
        if (m == 8) begin
          // Scaled register word form on the second operand
          r.opnd[1].base = ice_pkg::M_REG;
          r.opnd[1].scale = ice_pkg::SC_W;
          r.opnd[1].ea_need = 1'b1;
        end
        send(r, 1'b1);
      end
    end
    $display("test modes done");
    // Write wait states around both hiding limits
    for (int w = 0; w < 16; w++) begin
      for (int l = 0; l < 3; l++) begin
        r = rnd();
        r.str_en = 1'b1;
        r.str_waits = 4'(w);
        r.op_len = ice_pkg::ice_size_e'(l);
        r.n1 = 8'hC8;
        r.n2 = 8'hF0; // Range stays ordered above the raised minimum
        send(r, 1'b1);
      end
    end
    $display("test string done");
    // Each overhead form with both float sizes
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      r.tcy_kind = ice_pkg::ice_tcy_e'(k % 3);
      r.fp_en = 1'b1;
      r.fp_long = 1'(k / 3);
      send(r, 1'b1);
    end
    $display("test overhead done");
    // Random traffic with idle gaps
    repeat (400) send(rnd(), 1'($urandom_range(1)));
    $display("test random done");
    // Reset in mid-run with a request pending
    send(rnd(), 1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(negedge clk);
    sys_rst <= 1'b0;
    send(rnd(), 1'b1);
    send(rnd(), 1'b0);
    repeat (2) @(negedge clk);
    $display("test reset done");
    complete_run();
  end
endmodule
